// File: hw/mqla_fabric_end.sv
/*
 * Fabric end: issues register accesses from a command port, drives the
 * common resync and align enables, and stands in as the peer chip on the
 * link. Assumes command and control inputs are on clock.
 */
`timescale 1ns/1ps
module mqla_fabric_end (
    input  wire logic         clock,
    input  wire logic         rst,
    mqla_if.host              bus,
    input  wire logic         cmd_valid,
    input  wire logic         cmd_write,
    input  mqla_pkg::mqla_space_t cmd_space,
    input  wire logic [7:0]   cmd_addr,
    input  wire logic [7:0]   cmd_wdata,
    output logic              cmd_ready,
    output logic              rsp_valid,
    output logic [7:0]        rsp_data,
    input  wire logic [3:0]   align_en_req,
    input  wire logic         resync_req,
    input  wire logic         resync23_req,
    input  wire logic         peer_aligned,
    output logic              dev_done,
    output logic              link_tick
);
    import mqla_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    mqla_hstate_t state;
    mqla_hstate_t next_state;
    logic         is_read;
    logic [1:0]   lk_s1;
    logic [1:0]   lk_s2;
    logic         lk_prev;
    logic         dn_s1;
    logic         dn_s2;

    wire take = (state == H_IDLE) & cmd_valid;

    always_comb begin
        case (state)
            H_IDLE:  next_state = cmd_valid ? H_ISSUE : H_IDLE;
            H_ISSUE: next_state = is_read ? H_WAIT : H_IDLE;
            H_WAIT:  next_state = bus.reg_rvalid ? H_IDLE : H_WAIT;
            default: next_state = H_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state         <= H_IDLE;
            is_read       <= 1'b0;
            cmd_ready     <= 1'b0;
            rsp_valid     <= 1'b0;
            rsp_data      <= 8'h00;
            bus.reg_space <= SPACE_QUAD;
            bus.reg_addr  <= 8'h00;
            bus.reg_wdata <= 8'h00;
            bus.reg_wr    <= 1'b0;
            bus.reg_rd    <= 1'b0;
        end else begin
            state     <= next_state;
            cmd_ready <= (next_state == H_IDLE);
            rsp_valid <= (state == H_WAIT) & bus.reg_rvalid;
            if (take) begin
                is_read       <= ~cmd_write;
                bus.reg_space <= cmd_space;
                bus.reg_addr  <= cmd_addr;
                bus.reg_wdata <= cmd_wdata;
            end
            bus.reg_wr <= take & cmd_write;
            bus.reg_rd <= take & ~cmd_write;
            if ((state == H_WAIT) && bus.reg_rvalid) begin
                rsp_data <= bus.reg_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One resync request feeds every quad of the group in the same cycle.
    always_ff @(posedge clock) begin
        if (rst) begin
            bus.align_en  <= 4'h0;
            bus.resync_01 <= 1'b0;
            bus.resync_23 <= 1'b0;
            bus.done_peer <= 1'b0;
            lk_s1         <= 2'h0;
            lk_s2         <= 2'h0;
            lk_prev       <= 1'b0;
            dn_s1         <= 1'b0;
            dn_s2         <= 1'b0;
            dev_done      <= 1'b0;
            link_tick     <= 1'b0;
        end else begin
            bus.align_en  <= align_en_req; // R4
            bus.resync_01 <= resync_req; // R6
            bus.resync_23 <= resync23_req; // R5
            bus.done_peer <= peer_aligned; // R11
            lk_s1         <= bus.link_clk;
            lk_s2         <= lk_s1;
            lk_prev       <= lk_s2[0];
            dn_s1         <= bus.done_dev;
            dn_s2         <= dn_s1;
            dev_done      <= dn_s2;
            link_tick     <= lk_s2[0] & ~lk_prev; // R11
        end
    end
endmodule

// File: hw/mqla_if.sv
/*
 * Interface joining the quad end and the fabric end: register port,
 * fabric alignment controls and the four-signal chip-to-chip link.
 * Assumes both ends share the clock given here.
 */
`timescale 1ns/1ps
interface mqla_if (
    input wire logic clock
);
    import mqla_pkg::*;
    mqla_space_t reg_space;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        reg_rvalid;
    logic [3:0]  align_en;
    logic        resync_01;
    logic        resync_23;
    logic [1:0]  dev_clk;
    logic        dev_clk_oe;
    logic [1:0]  link_clk;
    logic        done_dev;
    logic        done_peer;

    // The alignment clocks only carry a level while the master drives them.
    assign link_clk = dev_clk_oe ? dev_clk : 2'h0;

    modport dev (
        input  reg_space, reg_addr, reg_wdata, reg_wr, reg_rd,
        output reg_rdata, reg_rvalid,
        input  align_en, resync_01, resync_23,
        output dev_clk, dev_clk_oe, done_dev,
        input  done_peer, link_clk
    );
    modport host (
        output reg_space, reg_addr, reg_wdata, reg_wr, reg_rd,
        input  reg_rdata, reg_rvalid,
        output align_en, resync_01, resync_23,
        input  done_dev, link_clk,
        output done_peer
    );
endinterface

// File: hw/mqla_irq_bit.sv
/*
 * One sticky status interrupt bit, cleared when read.
 * Assumes status is already synchronised to clock.
 */
`timescale 1ns/1ps
module mqla_irq_bit (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic status,
    input  wire logic clear,
    output logic      flag
);
    wire next_flag;

    // A status still high in the read cycle sets the bit again at once.
    assign next_flag = (flag & ~clear) | (enable & status); // R13 R14

    always_ff @(posedge clock) begin
        if (rst) begin
            flag <= 1'b0; // R19
        end else begin
            flag <= next_flag;
        end
    end
endmodule

// File: hw/mqla_pkg.sv
/*
 * Shared constants and types for the multi-quad lane alignment controller.
 * Assumes one 125 MHz clock on both ends and an 8-bit register port.
 */
package mqla_pkg;
    // Inter-quad register space.
    localparam logic [7:0] IQ_CFG_BASE = 8'h00;
    localparam logic [7:0] IQ_CFG_LAST = 8'h07;
    localparam logic [7:0] IQ_ROLE     = 8'h0A;
    // Quad register space.
    localparam logic [7:0] QR_LOCAL    = 8'h00;
    localparam logic [7:0] QR_CHAN_EN  = 8'h04;
    localparam logic [7:0] QR_IRQ_EN   = 8'h0C;
    localparam logic [7:0] QR_RESYNC   = 8'h41;
    localparam logic [7:0] QR_STATUS   = 8'h82;
    localparam logic [7:0] QR_IRQ      = 8'h83;
    // Field positions.
    localparam int MQ_EN_BIT   = 3;
    localparam int GRP_LSB     = 6;
    localparam int ROLE_LSB    = 6;
    localparam int RESYNC_BIT  = 7;
    localparam int ST_AL01_BIT = 2;
    localparam int ST_AL23_BIT = 3;
    // Field values and reset values.
    localparam logic [1:0] ROLE_MASTER = 2'h2;
    localparam logic [1:0] ROLE_SLAVE  = 2'h1;
    localparam logic [1:0] GROUP_ZERO  = 2'h0;
    localparam logic [7:0] REG_RESET   = 8'h00;
    // Alignment clock made by the master: half period in ns and in cycles.
    localparam int CLK_MHZ       = 125;
    localparam int LINK_HALF_NS  = 40;
    localparam int LINK_HALF_CYC = (LINK_HALF_NS * CLK_MHZ) / 1000;
    localparam logic [3:0] DIV_LAST = 4'(LINK_HALF_CYC - 1);

    typedef enum logic {
        SPACE_QUAD = 1'b0,
        SPACE_IQ   = 1'b1
    } mqla_space_t;

    typedef enum logic [2:0] {
        H_IDLE  = 3'b001,
        H_ISSUE = 3'b010,
        H_WAIT  = 3'b100
    } mqla_hstate_t;
endpackage

// File: hw/mqla_quad_end.sv
/*
 * Quad end: quad and inter-quad register spaces, channel align enables,
 * resync routing, group select decode, chip-to-chip link and status
 * interrupts. Assumes aligner status arrives from another clock domain
 * and fabric controls come from logic on this clock.
 */
// Summary of operation
// R1: Per-quad inter-quad enable at bit 3.
// R2: Software writes equal group select twice.
// R3: Group select 00..11 picks group 0..3.
// R4: Channel aligns via port or register 0x04.
// R5: Only channel 0/1 resync drives group.
// R6: Fabric drives one common resync signal.
// R7: Register resync bit resyncs this quad only.
// R8: Two-chip linking uses group 0 only.
// R9: Channel 0/1 aligned invalid across chips.
// R10: Role field 10 master, 01 slave.
// R11: Link: two dones, two master clocks.
// R12: Software enables interrupt before expecting it.
// R13: Enabled status sets sticky interrupt bit.
// R14: Read clears; still-high status sets again.
// R15: Any interrupt bit raises the request.
// R16: Channel 0/1 alignment at status bit 2.
// R17: Channel 2/3 status bit 3, off in x4.
// R18: Quad local bit 3 also enables.
// R19: Reset clears interrupt and enable bits.
`timescale 1ns/1ps
module mqla_quad_end #(
    parameter logic [2:0] QUAD_INDEX = 3'h0
) (
    input  wire logic  clock,
    input  wire logic  rst,
    mqla_if.dev        bus,
    input  wire logic  aligned_01,
    input  wire logic  aligned_23,
    input  wire logic  four_chan_mode,
    output logic [3:0] grp_sel,
    output logic       mq_enable,
    output logic [3:0] chan_align_en,
    output logic       aligner_resync_01,
    output logic       aligner_resync_23,
    output logic       group_resync,
    output logic       aligned_01_valid,
    output logic       irq,
    output logic       chip_master,
    output logic       chip_slave,
    output logic       link_tick
);
    import mqla_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] iq_cfg [0:7];
    logic [7:0] iq_role;
    logic [7:0] q_local;
    logic [7:0] q_chan_en;
    logic [7:0] q_irq_en;
    logic [2:0] st_s1;
    logic [2:0] st_s2;
    logic [1:0] lk_s1;
    logic [1:0] lk_s2;
    logic       lk_prev;
    logic       dn_s1;
    logic       dn_s2;
    logic [3:0] div_cnt;
    logic [1:0] mclk;
    logic [1:0] irq_flag;

    wire is_quad   = (bus.reg_space == SPACE_QUAD);
    wire is_iq     = (bus.reg_space == SPACE_IQ);
    wire wr_q      = bus.reg_wr & is_quad;
    wire wr_iq     = bus.reg_wr & is_iq;
    wire iq_cfg_hit = (bus.reg_addr >= IQ_CFG_BASE) && (bus.reg_addr <= IQ_CFG_LAST);
    wire [2:0] iq_idx = bus.reg_addr[2:0];
    wire rd_irq    = bus.reg_rd & is_quad & (bus.reg_addr == QR_IRQ);
    wire resync_wr = wr_q & (bus.reg_addr == QR_RESYNC) & bus.reg_wdata[RESYNC_BIT]; // R7

    wire [7:0] own_iq   = iq_cfg[QUAD_INDEX];
    wire       next_mq  = q_local[MQ_EN_BIT] & own_iq[MQ_EN_BIT]; // R1 R18
    wire [1:0] grp_code = q_local[GRP_LSB +: 2];
    wire [1:0] role     = iq_role[ROLE_LSB +: 2];
    wire       is_m     = (role == ROLE_MASTER); // R10
    wire       is_s     = (role == ROLE_SLAVE); // R10
    wire       link_act = (is_m | is_s) & next_mq & (grp_code == GROUP_ZERO); // R8
    wire       st_al01  = st_s2[0];
    wire       st_al23  = st_s2[1] & ~st_s2[2]; // R17
    wire [7:0] status_v = {4'h0, st_al23, st_al01, 2'h0}; // R16 R17

    wire [7:0] q_rdata =
        (bus.reg_addr == QR_LOCAL)  ? q_local :
        (bus.reg_addr == QR_CHAN_EN) ? q_chan_en :
        (bus.reg_addr == QR_IRQ_EN) ? q_irq_en :
        (bus.reg_addr == QR_STATUS) ? status_v :
        (bus.reg_addr == QR_IRQ)    ? {4'h0, irq_flag, 2'h0} : 8'h00;
    wire [7:0] iq_rdata =
        iq_cfg_hit                  ? iq_cfg[iq_idx] :
        (bus.reg_addr == IQ_ROLE)   ? iq_role : 8'h00;
    wire [7:0] next_rdata = is_iq ? iq_rdata : q_rdata;

    ////////////////////////////////////////////////////////////////////////
    // Register writes. The resync register is write-only and reads as zero.
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                iq_cfg[i] <= REG_RESET;
            end
            iq_role   <= REG_RESET;
            q_local   <= REG_RESET;
            q_chan_en <= REG_RESET;
            q_irq_en  <= REG_RESET; // R19
        end else begin
            if (wr_iq && iq_cfg_hit) begin
                iq_cfg[iq_idx] <= bus.reg_wdata; // R1 R2
            end
            if (wr_iq && bus.reg_addr == IQ_ROLE) begin
                iq_role <= bus.reg_wdata; // R10
            end
            if (wr_q && bus.reg_addr == QR_LOCAL) begin
                q_local <= bus.reg_wdata; // R2 R18
            end
            if (wr_q && bus.reg_addr == QR_CHAN_EN) begin
                q_chan_en <= bus.reg_wdata; // R4
            end
            if (wr_q && bus.reg_addr == QR_IRQ_EN) begin
                q_irq_en <= bus.reg_wdata; // R12
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            bus.reg_rdata  <= 8'h00;
            bus.reg_rvalid <= 1'b0;
        end else begin
            bus.reg_rvalid <= bus.reg_rd;
            bus.reg_rdata  <= bus.reg_rd ? next_rdata : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Aligner status and link inputs come from other domains.
    always_ff @(posedge clock) begin
        if (rst) begin
            st_s1   <= 3'h0;
            st_s2   <= 3'h0;
            lk_s1   <= 2'h0;
            lk_s2   <= 2'h0;
            lk_prev <= 1'b0;
            dn_s1   <= 1'b0;
            dn_s2   <= 1'b0;
        end else begin
            st_s1   <= {four_chan_mode, aligned_23, aligned_01};
            st_s2   <= st_s1;
            lk_s1   <= bus.link_clk;
            lk_s2   <= lk_s1;
            lk_prev <= lk_s2[0];
            dn_s1   <= bus.done_peer;
            dn_s2   <= dn_s1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_irq
            mqla_irq_bit u_bit (
                .clock  (clock),
                .rst    (rst),
                .enable (q_irq_en[ST_AL01_BIT + g]),
                .status (status_v[ST_AL01_BIT + g]),
                .clear  (rd_irq),
                .flag   (irq_flag[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // The master derives both link clocks from clock; the second runs at
    // half the rate of the first so the slave can tell them apart.
    wire div_wrap  = (div_cnt == DIV_LAST);
    wire m_rise    = div_wrap & ~mclk[0];
    wire s_rise    = lk_s2[0] & ~lk_prev;

    always_ff @(posedge clock) begin
        if (rst || !(link_act && is_m)) begin
            div_cnt <= 4'h0;
            mclk    <= 2'h0;
        end else if (div_wrap) begin
            div_cnt <= 4'h0;
            mclk[0] <= ~mclk[0];
            mclk[1] <= m_rise ? ~mclk[1] : mclk[1];
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            bus.dev_clk       <= 2'h0;
            bus.dev_clk_oe    <= 1'b0;
            bus.done_dev      <= 1'b0;
            grp_sel           <= 4'h0;
            mq_enable         <= 1'b0;
            chan_align_en     <= 4'h0;
            aligner_resync_01 <= 1'b0;
            aligner_resync_23 <= 1'b0;
            group_resync      <= 1'b0;
            aligned_01_valid  <= 1'b0;
            irq               <= 1'b0;
            chip_master       <= 1'b0;
            chip_slave        <= 1'b0;
            link_tick         <= 1'b0;
        end else begin
            bus.dev_clk       <= mclk; // R11
            bus.dev_clk_oe    <= link_act & is_m; // R11
            bus.done_dev      <= link_act & st_al01 & dn_s2; // R11
            grp_sel           <= 4'h1 << grp_code; // R3
            mq_enable         <= next_mq;
            chan_align_en     <= bus.align_en | q_chan_en[3:0]; // R4
            aligner_resync_01 <= bus.resync_01 | resync_wr; // R7
            aligner_resync_23 <= bus.resync_23; // R5
            group_resync      <= next_mq & bus.resync_01; // R5 R6
            aligned_01_valid  <= st_al01 & ~link_act; // R9
            irq               <= |irq_flag; // R15
            chip_master       <= link_act & is_m;
            chip_slave        <= link_act & is_s;
            link_tick         <= link_act & (is_m ? m_rise : s_rise);
        end
    end
endmodule

// File: verification/mqla_props.sv
/*
 * Checker on the register port and the chip link carried by mqla_if.
 * Assumes one clock domain, a synchronous active-high reset and quad index 0.
 */
`timescale 1ns/1ps
module mqla_props (
    input wire logic             clock,
    input wire logic             rst,
    input mqla_pkg::mqla_space_t reg_space,
    input wire logic [7:0]       reg_addr,
    input wire logic [7:0]       reg_wdata,
    input wire logic             reg_wr,
    input wire logic             reg_rd,
    input wire logic [7:0]       reg_rdata,
    input wire logic             reg_rvalid,
    input wire logic [1:0]       dev_clk,
    input wire logic             dev_clk_oe,
    input wire logic             done_dev,
    input wire logic             done_peer
);
    import mqla_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Shadow of every write, so read data can be judged without the design.
    logic [7:0] sh [0:1][0:255];
    always_ff @(posedge clock) begin
        if (rst) begin
            sh <= '{default: 8'h00};
        end else if (reg_wr) begin
            sh[reg_space][reg_addr] <= reg_wdata;
        end
    end

    wire       in_iq  = reg_space == SPACE_IQ;
    wire [7:0] iq_m   = reg_addr <= IQ_CFG_LAST ? 8'hC8 : (reg_addr == IQ_ROLE ? 8'hC0 : 8'h00);
    wire [7:0] qd_m   = reg_addr == QR_LOCAL ? 8'hC8 : reg_addr == QR_CHAN_EN ? 8'h0F
                      : reg_addr == QR_IRQ_EN ? 8'h0C : 8'h00;
    wire [7:0] mask   = in_iq ? iq_m : qd_m;
    wire       st_rd  = !in_iq && (reg_addr == QR_STATUS || reg_addr == QR_IRQ);
    wire [7:0] exp_rd = sh[reg_space][reg_addr] & mask;
    wire [7:0] irq_en = sh[SPACE_QUAD][QR_IRQ_EN];
    wire [1:0] role   = sh[SPACE_IQ][IQ_ROLE][7:6];
    wire [1:0] group  = sh[SPACE_QUAD][QR_LOCAL][7:6];

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    AST_RVALID: assert property (reg_rvalid == $past(reg_rd))
        else $error("read answer not one cycle after the strobe");
    AST_RDATA_IDLE: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
        else $error("read data not zero outside an answer");
    AST_RDATA_RW: assert property (
        reg_rd && mask != 8'h00 |=> (reg_rdata & $past(mask)) == $past(exp_rd))
        else $error("register read back differs from last write");
    AST_RDATA_ZERO: assert property (
        reg_rd && mask == 8'h00 && !st_rd |=> reg_rdata == 8'h00)
        else $error("unmapped or resync register read not zero");
    AST_FLAG_GATED: assert property (
        reg_rd && !in_iq && reg_addr == QR_IRQ |=> (reg_rdata & ~$past(irq_en)) == 8'h00)
        else $error("interrupt flag set while its enable is clear");
    AST_MASTER_ROLE: assert property ($rose(dev_clk_oe) |-> role == ROLE_MASTER)
        else $error("alignment clocks driven without master role");
    AST_GROUP_ZERO: assert property ($rose(dev_clk_oe) |-> group == GROUP_ZERO)
        else $error("alignment clocks driven outside group zero");
    AST_LINK_DIV: assert property (
        dev_clk_oe && $past(dev_clk_oe) && $changed(dev_clk[0])
        |=> (!dev_clk_oe || $stable(dev_clk[0]))[*4] ##1 (!dev_clk_oe || $changed(dev_clk[0])))
        else $error("alignment clock half period is not five cycles");
    AST_DONE_RISE: assert property ($rose(done_dev) |-> $past(done_peer, 2))
        else $error("done raised without the peer done");
    AST_DONE_FALL: assert property ($fell(done_peer) |-> ##[1:6] !done_dev)
        else $error("done kept after the peer withdrew");

    COV_MASTER: cover property ($rose(dev_clk_oe));
    COV_FLAG: cover property (reg_rd && !in_iq && reg_addr == QR_IRQ ##1 reg_rdata[2]);
    COV_DONE: cover property ($rose(done_dev));
endmodule

// File: verification/tb_top.sv
/*
 * Testbench: quad end and fabric end joined by mqla_if, driven from the
 * fabric command port and the quad status inputs.
 * Assumes the fabric end is the only register master.
 */
`timescale 1ns/1ps
module tb_top;
    import mqla_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        cmd_valid = 1'b0;
    logic        cmd_write = 1'b0;
    mqla_space_t cmd_space = SPACE_QUAD;
    logic [7:0]  cmd_addr = 8'h00;
    logic [7:0]  cmd_wdata = 8'h00;
    logic [3:0]  align_en_req = 4'h0;
    logic        resync_req = 1'b0;
    logic        resync23_req = 1'b0;
    logic        peer_aligned = 1'b0;
    logic        aligned_01 = 1'b0;
    logic        aligned_23 = 1'b0;
    logic        four_chan_mode = 1'b0;
    logic [3:0]  grp_sel, chan_en;
    logic        mq_en, rs01, rs23, grp_rs, a01_valid, irq, master, slave;
    logic        q_tick, f_tick, cmd_ready, rsp_valid, dev_done;
    logic [7:0]  rsp_data, q;
    int          fails = 0;
    int          tests_run = 0;
    int          n_rs01 = 0, n_grp = 0, n_qt = 0, n_ft = 0, b0, b1;

    always #4 clock = ~clock;

    mqla_if bus (.clock(clock));
    mqla_quad_end #(.QUAD_INDEX(3'h0)) u_mqla_quad_end (.clock(clock), .rst(rst), .bus(bus),
        .aligned_01(aligned_01), .aligned_23(aligned_23), .four_chan_mode(four_chan_mode),
        .grp_sel(grp_sel), .mq_enable(mq_en), .chan_align_en(chan_en),
        .aligner_resync_01(rs01), .aligner_resync_23(rs23), .group_resync(grp_rs),
        .aligned_01_valid(a01_valid), .irq(irq), .chip_master(master),
        .chip_slave(slave), .link_tick(q_tick));
    mqla_fabric_end u_mqla_fabric_end (.clock(clock), .rst(rst), .bus(bus),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_space(cmd_space),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .align_en_req(align_en_req),
        .resync_req(resync_req), .resync23_req(resync23_req), .peer_aligned(peer_aligned),
        .dev_done(dev_done), .link_tick(f_tick));
    mqla_props u_mqla_props (.clock(clock), .rst(rst), .reg_space(bus.reg_space),
        .reg_addr(bus.reg_addr), .reg_wdata(bus.reg_wdata), .reg_wr(bus.reg_wr),
        .reg_rd(bus.reg_rd), .reg_rdata(bus.reg_rdata), .reg_rvalid(bus.reg_rvalid),
        .dev_clk(bus.dev_clk), .dev_clk_oe(bus.dev_clk_oe), .done_dev(bus.done_dev),
        .done_peer(bus.done_peer));

    // Pulses are counted at the rising edge, where they are settled.
    always @(posedge clock) begin
        if (rs01) n_rs01++;
        if (grp_rs) n_grp++;
        if (q_tick) n_qt++;
        if (f_tick) n_ft++;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic wait_cyc(input int k);
        repeat (k) @(negedge clock);
    endtask

    // A command is driven for one cycle once cmd_ready is seen; a refused one is lost.
    task automatic xfer(input logic w, input mqla_space_t sp, input logic [7:0] a, d);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 40) begin
            @(negedge clock);
            n++;
        end
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_space <= sp;
        cmd_addr  <= a;
        cmd_wdata <= d;
        @(posedge clock);
        cmd_valid <= 1'b0;
        wait_cyc(2);
        while (!w && rsp_valid !== 1'b1 && n < 40) begin
            @(negedge clock);
            n++;
        end
        if (n >= 40) fails++;
        q = rsp_data;
    endtask

    task automatic wr(input mqla_space_t sp, input logic [7:0] a, d);
        xfer(1'b1, sp, a, d);
    endtask

    task automatic rd(input mqla_space_t sp, input logic [7:0] a, exp, input string what);
        xfer(1'b0, sp, a, 8'h00);
        chk(what, exp, q);
    endtask

    initial begin
        repeat (8000) @(posedge clock);
        fails++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) rd(SPACE_IQ, 8'(i), 8'h00, "iq cfg reset");
        rd(SPACE_QUAD, QR_IRQ_EN, 8'h00, "irq enable reset");
        for (int i = 0; i < 8; i++) wr(SPACE_IQ, 8'(i), {2'(i), 2'h0, 1'(i), 3'h0});
        for (int i = 0; i < 8; i++) rd(SPACE_IQ, 8'(i), {2'(i), 2'h0, 1'(i), 3'h0}, "iq cfg");
        wr(SPACE_IQ, IQ_ROLE, 8'h40);
        rd(SPACE_IQ, IQ_ROLE, 8'h40, "role");
        wr(SPACE_IQ, IQ_ROLE, 8'h00);
        wr(SPACE_QUAD, QR_STATUS, 8'hFF);
        rd(SPACE_QUAD, QR_STATUS, 8'h00, "status write");
        rd(SPACE_IQ, 8'h20, 8'h00, "unmapped");
        for (int c = 0; c < 4; c++) begin
            wr(SPACE_IQ, IQ_CFG_BASE, {2'(c), 6'h08});
            wr(SPACE_QUAD, QR_LOCAL, {2'(c), 6'h08});
            wait_cyc(4);
            chk("group select", 8'(4'h1 << c), {4'h0, grp_sel});
            chk("quad enable", 8'h01, {7'h00, mq_en});
        end
        wr(SPACE_QUAD, QR_LOCAL, 8'h00);
        wait_cyc(4);
        chk("enable local off", 8'h00, {7'h00, mq_en});
        wr(SPACE_QUAD, QR_LOCAL, 8'h08);
        wr(SPACE_IQ, IQ_CFG_BASE, 8'h00);
        wait_cyc(4);
        chk("enable iq off", 8'h00, {7'h00, mq_en});
        @(posedge clock) align_en_req <= 4'h5;
        wr(SPACE_QUAD, QR_CHAN_EN, 8'h02);
        wr(SPACE_IQ, IQ_CFG_BASE, 8'h08);
        wr(SPACE_QUAD, QR_RESYNC, 8'h80);
        rd(SPACE_QUAD, QR_RESYNC, 8'h00, "resync read");
        chk("resync pulses", 8'h01, 8'(n_rs01));
        chk("group resync by reg", 8'h00, 8'(n_grp));
        @(posedge clock) resync23_req <= 1'b1;
        wait_cyc(5);
        chk("channel enables", 8'h07, {4'h0, chan_en});
        chk("resync 2/3", 8'h01, {7'h00, rs23});
        chk("group by 2/3", 8'h00, {7'h00, grp_rs});
        @(posedge clock) resync_req <= 1'b1;
        wait_cyc(5);
        chk("group resync", 8'h01, {7'h00, grp_rs});
        chk("resync 0/1", 8'h01, {7'h00, rs01});
        @(posedge clock) resync_req <= 1'b0;
        @(posedge clock) aligned_01 <= 1'b1;
        wait_cyc(6);
        rd(SPACE_QUAD, QR_STATUS, 8'h04, "status 0/1");
        rd(SPACE_QUAD, QR_IRQ, 8'h00, "flags disabled");
        chk("aligned valid", 8'h01, {7'h00, a01_valid});
        wr(SPACE_QUAD, QR_IRQ_EN, 8'h0C);
        wait_cyc(6);
        rd(SPACE_QUAD, QR_IRQ, 8'h04, "flag set");
        rd(SPACE_QUAD, QR_IRQ, 8'h04, "flag set again");
        @(posedge clock) aligned_01 <= 1'b0;
        wait_cyc(6);
        chk("irq request", 8'h01, {7'h00, irq});
        rd(SPACE_QUAD, QR_IRQ, 8'h04, "flag sticky");
        rd(SPACE_QUAD, QR_IRQ, 8'h00, "flag cleared");
        chk("irq cleared", 8'h00, {7'h00, irq});
        @(posedge clock) aligned_23 <= 1'b1;
        wait_cyc(6);
        rd(SPACE_QUAD, QR_STATUS, 8'h08, "status 2/3");
        rd(SPACE_QUAD, QR_IRQ, 8'h08, "flag 2/3");
        @(posedge clock) four_chan_mode <= 1'b1;
        @(posedge clock) aligned_01 <= 1'b1;
        @(posedge clock) peer_aligned <= 1'b1;
        wait_cyc(6);
        rd(SPACE_QUAD, QR_STATUS, 8'h04, "status x4");
        wr(SPACE_IQ, IQ_ROLE, 8'h80);
        wait_cyc(10);
        chk("master", 8'h01, {7'h00, master});
        chk("aligned invalid", 8'h00, {7'h00, a01_valid});
        chk("done to peer", 8'h01, {7'h00, dev_done});
        b0 = n_qt;
        b1 = n_ft;
        wait_cyc(100);
        chk("master ticks", 8'h0A, 8'(n_qt - b0));
        chk("peer ticks", 8'h0A, 8'(n_ft - b1));
        @(posedge clock) peer_aligned <= 1'b0;
        wait_cyc(10);
        chk("done withdrawn", 8'h00, {7'h00, dev_done});
        wr(SPACE_IQ, IQ_ROLE, 8'h40);
        wait_cyc(10);
        b1 = n_ft;
        chk("slave", 8'h01, {7'h00, slave});
        wait_cyc(20);
        chk("no slave clock", 8'h00, 8'(n_ft - b1));
        wr(SPACE_QUAD, QR_LOCAL, 8'h48);
        wr(SPACE_IQ, IQ_ROLE, 8'h80);
        wait_cyc(10);
        chk("master group 1", 8'h00, {7'h00, master});
        @(posedge clock) rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd(SPACE_QUAD, QR_IRQ_EN, 8'h00, "enable after reset");
        rd(SPACE_QUAD, QR_IRQ, 8'h00, "flags after reset");
        report_and_stop();
    end
endmodule
